// ==== hdl/srwd_pkg.sv ====
// srwd_pkg: constants for the stop recovery and watchdog control block
// assumes a 200 MHz system clock and an Avalon-MM register master
//
// Notes on behaviour
// R1 - polarity bit picks high or low wake
// R2 - warm flag set on STOP entry, read-only
// R3 - warm after source/watchdog wake, else cold
// R4 - primary and secondary selections are ORed
// R5 - output-configured pins excluded from wake logic
// R6 - retriggerable one-shot watchdog resets the device
// R7 - first refresh starts watchdog, later ones restart
// R8 - refresh updates zero, sign, overflow flags
// R9 - mode writes only in first 64 cycles; the code opens the window for 128 crystal clocks
// R10 - mode register write-only at offset 0x0f
// R11 - two tap bits select time-out period
// R12 - time select resets to code 01
// R13 - halt-activity bit gates counting in HALT
// R14 - stop-activity bit; counting in STOP needs RC
// R15 - clock-source bit selects crystal or RC
// R16 - bits 5 to 7 reserved, no effect
// R17 - reset-clear rising edge enables the timers
// R18 - low supply holds reset, then power-on sequence
// R19 - power-on one-shot 5 ms, three triggers; the code adds the reset-clear rising edge as a fourth
// R20 - primary recovery register at offset 0x0b
// R21 - refresh reloads full period
// R22 - time-out asserts reset and triggers one-shot
package srwd_pkg;

	// ----------------------------------------------------------------
	// register map (offsets compare directly with I_AVS_ADDRESS, no scaling)
	// ----------------------------------------------------------------
	localparam logic [3:0] SRWD_IDX_SRC   = 4'h0;  // see R20 (0x0b)
	localparam logic [3:0] SRWD_IDX_SRC2  = 4'h0;
	localparam logic [7:0] SRWD_OFF_SRC   = 8'h0b;
	localparam logic [7:0] SRWD_OFF_SRC2  = 8'h0d;
	localparam logic [7:0] SRWD_OFF_WDM   = 8'h0f;
	localparam logic [7:0] SRWD_OFF_STAT  = 8'h10;
	localparam logic [7:0] SRWD_OFF_CMD   = 8'h11;
	localparam logic [7:0] SRWD_OFF_PORTD = 8'h12;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int SRWD_SRC_DIV    = 0;
	localparam int SRWD_SRC_SELLO  = 2;
	localparam int SRWD_SRC_DELAY  = 5;
	localparam int SRWD_SRC_POL    = 6;
	localparam int SRWD_SRC_WARM   = 7;
	localparam int SRWD_WDM_HALT   = 2;
	localparam int SRWD_WDM_STOP   = 3;
	localparam int SRWD_WDM_XTAL   = 4;
	localparam int SRWD_CMD_REFR   = 0;
	localparam int SRWD_CMD_HALT   = 1;
	localparam int SRWD_CMD_STOP   = 2;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] SRWD_SRC_RST   = 8'h20;
	localparam logic [7:0] SRWD_SRC2_RST  = 8'h00;
	localparam logic [4:0] SRWD_WDM_RST   = 5'h0d;  // see R12 R13 R14 R15

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int SRWD_CLK_MHZ      = 200;
	localparam int SRWD_XTAL_DIV     = 25;   // crystal cycle, 8 MHz
	localparam int SRWD_RC_DIV       = 200;  // rc tick every 1 us
	localparam int SRWD_POR_US       = 5000;
	localparam int SRWD_WIN_XTAL     = 128;  // see R9
	localparam int SRWD_RSTT_XTAL    = 18;   // see R17
	localparam int SRWD_RC_MS0       = 5;
	localparam int SRWD_US_PER_MS    = 1000;

	typedef enum logic [1:0] {
		SRWD_RUN,
		SRWD_HALTED,
		SRWD_STOPPED
	} srwd_mode_t;

endpackage : srwd_pkg

// ==== hdl/srwd_ctrl.sv ====
// srwd_ctrl: stop-mode wake control, watchdog and supply reset
// assumes core strobes are synchronous to I_MCLK, one cycle each
//
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
module srwd_ctrl (
	// clock and reset
	input  wire logic        I_MCLK,
	input  wire logic        I_RST,
	// avalon-mm slave
	input  wire logic [7:0]  I_AVS_ADDRESS,
	input  wire logic        I_AVS_READ,
	input  wire logic        I_AVS_WRITE,
	input  wire logic [31:0] I_AVS_WRITEDATA,
	output logic [31:0]      O_AVS_READDATA,
	output logic             O_AVS_WAITREQUEST,
	// core side
	input  wire logic        I_WDT_INSTR,
	input  wire logic        I_HALT_ENTER,
	input  wire logic        I_STOP_ENTER,
	input  wire logic        I_CORE_WAKE,
	output logic [2:0]       O_FLAGS_ZSV,
	output logic             O_FLAGS_WE,
	// pins and supply
	input  wire logic [7:0]  I_PORT2_IN,
	input  wire logic [2:0]  I_PORT3_IN,
	input  wire logic        I_SUPPLY_LOW,
	input  wire logic        I_RESET_CLEAR_FIRST_N,
	input  wire logic        I_RESET_CLEAR_SECOND_N,
	// reset and status
	output logic             O_DEVICE_RESET,
	output logic             O_STOPPED,
	output logic             O_HALTED
);
	import srwd_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [7:0]  src_q;
	logic [7:0]  src2_q;
	logic [7:0]  port2_out_q;
	logic [4:0]  wdm_q;
	logic        warm_q;
	srwd_mode_t  mode_q;
	logic        wdt_on_q;
	logic [16:0] wdt_cnt_q;
	logic [12:0] por_cnt_q;
	logic        por_busy_q;
	logic [7:0]  win_cnt_q;
	logic [4:0]  rstt_cnt_q;
	logic [4:0]  xdiv_q;
	logic [7:0]  rdiv_q;
	logic        clr_q;
	logic        sup_low_q;
	logic        ack_q;
	logic        tick_x;
	logic        tick_r;
	logic        tick_w;
	logic        wdt_to;
	logic        wake;
	logic        wr;
	logic        rd;

	// 80 ms on the rc tick needs seventeen bits
	function automatic logic [16:0] srwd_period(input logic [1:0] sel,
	                                            input logic       xtal);
		logic [16:0] p;
		p = 17'h00000;
		if (xtal) begin  // see R11
			case (sel)
				2'b00:   p = 17'h00100;
				2'b01:   p = 17'h00200;
				2'b10:   p = 17'h00400;
				default: p = 17'h01000;
			endcase
		end else begin
			case (sel)  // microseconds on the rc tick
				2'b00:   p = 17'(SRWD_RC_MS0 * SRWD_US_PER_MS);
				2'b01:   p = 17'(2 * SRWD_RC_MS0 * SRWD_US_PER_MS);
				2'b10:   p = 17'(4 * SRWD_RC_MS0 * SRWD_US_PER_MS);
				default: p = 17'(16 * SRWD_RC_MS0 * SRWD_US_PER_MS);
			endcase
		end
		return p;
	endfunction : srwd_period

	// ----------------------------------------------------------------
	// avalon slave: one wait cycle, then answer
	// ----------------------------------------------------------------
	assign O_AVS_WAITREQUEST = (I_AVS_READ | I_AVS_WRITE) & ~ack_q;
	assign wr = I_AVS_WRITE & ack_q;
	assign rd = I_AVS_READ & ack_q;

	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= (I_AVS_READ | I_AVS_WRITE) & ~ack_q;
		end
	end

	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST) begin
			O_AVS_READDATA <= 32'h0000_0000;
		end else if ((I_AVS_READ | I_AVS_WRITE) & ~ack_q) begin
			O_AVS_READDATA <= 32'h0000_0000;
			if (I_AVS_READ) begin
				case (I_AVS_ADDRESS)
					// only the warm flag reads back; see R2
					SRWD_OFF_SRC:  O_AVS_READDATA[7] <= warm_q;
					SRWD_OFF_SRC2: O_AVS_READDATA[7:0] <= src2_q & 8'ha3;
					SRWD_OFF_PORTD: O_AVS_READDATA[7:0] <= port2_out_q;
					SRWD_OFF_STAT: O_AVS_READDATA[7:0] <= {
						2'b00, por_busy_q, wdt_on_q, O_DEVICE_RESET,
						win_cnt_q != 8'h00, mode_q == SRWD_STOPPED,
						mode_q == SRWD_HALTED};
					default: O_AVS_READDATA <= 32'h0000_0000; // see R10
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// clock enables: crystal and rc
	// ----------------------------------------------------------------
	assign tick_x = (xdiv_q == 5'(SRWD_XTAL_DIV - 1));
	assign tick_r = (rdiv_q == 8'(SRWD_RC_DIV - 1));
	// crystal halted in STOP; see R14 R15
	assign tick_w = wdm_q[SRWD_WDM_XTAL] ?
	                (tick_x & (mode_q != SRWD_STOPPED)) : tick_r;

	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST) begin
			xdiv_q <= 5'h00;
			rdiv_q <= 8'h00;
		end else begin
			xdiv_q <= tick_x ? 5'h00 : xdiv_q + 5'h01;
			rdiv_q <= tick_r ? 8'h00 : rdiv_q + 8'h01;
		end
	end

	// ----------------------------------------------------------------
	// stop recovery source logic
	// ----------------------------------------------------------------
	logic [7:0] p2_lo;
	logic [7:0] p2_hi;
	logic       pol;
	logic       src_a;
	logic       src_b;
	logic [2:0] lvl3;

	// level seen by the wake detector; see R1
	function automatic logic srwd_lvl(input logic x, input logic high);
		return high ? x : ~x;
	endfunction : srwd_lvl

	// an output pin takes the neutral level of each gate, so only the
	// input pins vote; a lone output pin never wakes; see R5
	assign p2_lo = I_PORT2_IN & ~port2_out_q;
	assign p2_hi = I_PORT2_IN | port2_out_q;
	assign pol   = src_q[SRWD_SRC_POL];
	assign lvl3  = pol ? I_PORT3_IN : ~I_PORT3_IN;

	always_comb begin
		src_a = 1'b0;
		case (src_q[4:2])  // see R1
			3'b010: src_a = lvl3[0];
			3'b011: src_a = lvl3[1];
			3'b100: src_a = lvl3[2];
			3'b101: src_a = ~port2_out_q[7] & srwd_lvl(I_PORT2_IN[7], pol);
			3'b110: src_a = srwd_lvl(~(|p2_lo[3:0]), pol);
			3'b111: src_a = srwd_lvl(~(|p2_lo), pol);
			default: src_a = 1'b0;
		endcase
	end

	always_comb begin
		src_b = 1'b0;
		case (src2_q[4:2])
			3'b001: src_b = srwd_lvl(~(&p2_hi[3:0]), pol);
			3'b010: src_b = srwd_lvl(~(&p2_hi), pol);
			3'b011: src_b = srwd_lvl(~(|p2_lo[3:0]), pol);
			3'b100: src_b = lvl3[0] & lvl3[1];
			3'b101: src_b = lvl3[0] & lvl3[2];
			3'b110: src_b = lvl3[1] & lvl3[2];
			3'b111: src_b = &lvl3;
			default: src_b = 1'b0;
		endcase
	end

	assign wake = (mode_q == SRWD_STOPPED) & (src_a | src_b);  // see R4

	// ----------------------------------------------------------------
	// registers written by software
	// ----------------------------------------------------------------
	logic win_open;
	assign win_open = (win_cnt_q != 8'h00);

	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST) begin
			src_q       <= SRWD_SRC_RST;
			src2_q      <= SRWD_SRC2_RST;
			port2_out_q <= 8'h00;
		end else begin
			if (wake)
				src_q[SRWD_SRC_DIV] <= 1'b0;
			if (wr && I_AVS_ADDRESS == SRWD_OFF_SRC)
				src_q[6:0] <= I_AVS_WRITEDATA[6:0];  // see R2
			if (wr && I_AVS_ADDRESS == SRWD_OFF_SRC2)
				src2_q <= I_AVS_WRITEDATA[7:0];
			if (wr && I_AVS_ADDRESS == SRWD_OFF_PORTD)
				port2_out_q <= I_AVS_WRITEDATA[7:0];
		end
	end

	// mode register, writable any number of times while the window is open
	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST) begin
			wdm_q <= SRWD_WDM_RST;
		end else if (wr && I_AVS_ADDRESS == SRWD_OFF_WDM && win_open) begin
			wdm_q <= I_AVS_WRITEDATA[4:0];  // see R9 R16
		end
	end

	// window of 128 crystal clocks after each reset release
	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST) begin
			win_cnt_q <= 8'(SRWD_WIN_XTAL);
		end else if (O_DEVICE_RESET) begin
			win_cnt_q <= 8'(SRWD_WIN_XTAL);  // see R9
		end else if (tick_x && win_open) begin
			win_cnt_q <= win_cnt_q - 8'h01;
		end
	end

	// ----------------------------------------------------------------
	// core mode tracking and warm flag
	// ----------------------------------------------------------------
	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST) begin
			mode_q <= SRWD_RUN;
		end else if (O_DEVICE_RESET || wake || wdt_to) begin
			mode_q <= SRWD_RUN;
		end else begin
			case (mode_q)
				SRWD_RUN: begin
					if (I_STOP_ENTER)
						mode_q <= SRWD_STOPPED;
					else if (I_HALT_ENTER)
						mode_q <= SRWD_HALTED;
				end
				SRWD_HALTED: begin
					if (I_CORE_WAKE)
						mode_q <= SRWD_RUN;
				end
				SRWD_STOPPED: mode_q <= SRWD_STOPPED;
				default: mode_q <= SRWD_RUN;
			endcase
		end
	end

	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST) begin
			warm_q <= 1'b0;
		end else if (mode_q == SRWD_RUN && I_STOP_ENTER) begin
			warm_q <= 1'b1;  // see R2
		end else if (sup_low_q || (wdt_to && mode_q != SRWD_STOPPED)) begin
			warm_q <= 1'b0;  // see R3
		end
	end

	// ----------------------------------------------------------------
	// watchdog: retriggerable one-shot
	// ----------------------------------------------------------------
	logic wdt_run;
	always_comb begin
		case (mode_q)
			SRWD_HALTED:  wdt_run = wdm_q[SRWD_WDM_HALT];  // see R13
			SRWD_STOPPED: wdt_run = wdm_q[SRWD_WDM_STOP];  // see R14
			default:      wdt_run = 1'b1;
		endcase
	end

	// a refresh in the terminal cycle wins, so no reset then
	assign wdt_to = wdt_on_q & tick_w & wdt_run & ~I_WDT_INSTR &
	                (wdt_cnt_q == 17'h00001);

	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST) begin
			wdt_on_q  <= 1'b0;
			wdt_cnt_q <= 17'h00000;
		end else if (I_WDT_INSTR && !O_DEVICE_RESET) begin
			wdt_on_q  <= 1'b1;  // see R7
			wdt_cnt_q <= srwd_period(wdm_q[1:0],
			                         wdm_q[SRWD_WDM_XTAL]);  // see R21
		end else if (wdt_to) begin
			wdt_on_q  <= 1'b0;  // see R6
			wdt_cnt_q <= 17'h00000;
		end else if (wdt_on_q && tick_w && wdt_run) begin
			wdt_cnt_q <= wdt_cnt_q - 17'h00001;
		end
	end

	// refresh flags: zero and overflow clear, sign clear; see R8
	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST) begin
			O_FLAGS_ZSV <= 3'b000;
			O_FLAGS_WE  <= 1'b0;
		end else begin
			O_FLAGS_WE  <= I_WDT_INSTR & ~O_DEVICE_RESET;
			O_FLAGS_ZSV <= 3'b000;
		end
	end

	// ----------------------------------------------------------------
	// supply, reset-clear and power-on one-shot
	// ----------------------------------------------------------------
	logic clr_now;
	logic por_trig;
	assign clr_now = I_RESET_CLEAR_FIRST_N & I_RESET_CLEAR_SECOND_N;
	// rising supply, time-out, or delayed stop recovery; see R19 R22
	assign por_trig = (sup_low_q & ~I_SUPPLY_LOW) | wdt_to |
	                  (wake & src_q[SRWD_SRC_DELAY]) |
	                  (clr_now & ~clr_q);  // see R17

	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST) begin
			sup_low_q <= 1'b0;
			// pins idle high; a zero here would fake a release edge
			clr_q     <= 1'b1;
		end else begin
			sup_low_q <= I_SUPPLY_LOW;
			clr_q     <= clr_now;
		end
	end

	// slow one-shot; the short reset timer follows on the crystal
	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST) begin
			// block reset assumes a good supply; the slow one-shot
			// fires only on its own triggers
			por_busy_q <= 1'b0;
			por_cnt_q  <= 13'h0000;
		end else if (I_SUPPLY_LOW || por_trig) begin
			por_busy_q <= 1'b1;  // see R18
			por_cnt_q  <= 13'(SRWD_POR_US);
		end else if (por_busy_q && tick_r) begin
			por_cnt_q <= por_cnt_q - 13'h0001;
			if (por_cnt_q == 13'h0001)
				por_busy_q <= 1'b0;
		end
	end

	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST) begin
			rstt_cnt_q <= 5'(SRWD_RSTT_XTAL);
		end else if (por_busy_q || wake) begin
			rstt_cnt_q <= 5'(SRWD_RSTT_XTAL);  // see R17
		end else if (tick_x && rstt_cnt_q != 5'h00) begin
			rstt_cnt_q <= rstt_cnt_q - 5'h01;
		end
	end

	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST) begin
			O_DEVICE_RESET <= 1'b1;
		end else begin
			O_DEVICE_RESET <= I_SUPPLY_LOW | por_busy_q | por_trig |
			                  wake | (rstt_cnt_q != 5'h00);  // see R22
		end
	end

	assign O_STOPPED = (mode_q == SRWD_STOPPED);
	assign O_HALTED  = (mode_q == SRWD_HALTED);

endmodule : srwd_ctrl

// ==== testbench/srwd_ctrl_monitor.sv ====
// srwd_ctrl_monitor: port-level checks for the stop/watchdog block
// assumes one I_MCLK domain and an asynchronous active-high I_RST
`timescale 1ns/1ps
module srwd_ctrl_monitor
	import srwd_pkg::*;
#(
	parameter int RST_MIN = (SRWD_RSTT_XTAL - 2) * SRWD_XTAL_DIV
) (
	// watched ports
	input wire logic        I_MCLK,
	input wire logic        I_RST,
	input wire logic        I_AVS_READ,
	input wire logic        I_AVS_WRITE,
	input wire logic [31:0] O_AVS_READDATA,
	input wire logic        O_AVS_WAITREQUEST,
	input wire logic        I_WDT_INSTR,
	input wire logic        I_HALT_ENTER,
	input wire logic        I_STOP_ENTER,
	input wire logic        I_CORE_WAKE,
	input wire logic [2:0]  O_FLAGS_ZSV,
	input wire logic        O_FLAGS_WE,
	input wire logic        I_SUPPLY_LOW,
	input wire logic        O_DEVICE_RESET,
	input wire logic        O_STOPPED,
	input wire logic        O_HALTED
);
	logic [20:0] hi_cnt_q;

	default clocking cb @(posedge I_MCLK); endclocking
	default disable iff (I_RST);

	// ----------------------------------------------------------------
	// helper counters
	// ----------------------------------------------------------------
	// saturating, so a long device reset never wraps the count
	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST) begin
			hi_cnt_q <= 21'h0;
		end else if (!O_DEVICE_RESET) begin
			hi_cnt_q <= 21'h0;
		end else if (hi_cnt_q < 21'(RST_MIN)) begin
			hi_cnt_q <= hi_cnt_q + 21'h1;
		end
	end

	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	sequence s_req_start;
		$rose(I_AVS_READ || I_AVS_WRITE);
	endsequence
	sequence s_two_phase;
		O_AVS_WAITREQUEST ##1 !O_AVS_WAITREQUEST;
	endsequence

	a_bus_two_phase: assert property (s_req_start |-> s_two_phase)
		else $error("bus answer not in second cycle");
	a_rdata_hold: assert property (!(I_AVS_READ || I_AVS_WRITE)
		|=> $stable(O_AVS_READDATA)) else $error("read data moved idle");
	a_flags_pulse: assert property (I_WDT_INSTR && !O_DEVICE_RESET
		|=> O_FLAGS_WE && O_FLAGS_ZSV == 3'h0) else $error("no flag update");
	a_flags_cause: assert property (O_FLAGS_WE |-> $past(I_WDT_INSTR))
		else $error("flag update without instruction");
	a_por_span: assert property ($fell(O_DEVICE_RESET)
		|-> hi_cnt_q >= 21'(RST_MIN)) else $error("device reset too short");
	a_supply_reset: assert property (I_SUPPLY_LOW [*3]
		|-> O_DEVICE_RESET) else $error("low supply without reset");
	a_halt_entry: assert property (I_HALT_ENTER && !O_DEVICE_RESET
		&& !O_STOPPED |=> O_HALTED) else $error("halt not entered");
	a_halt_wake: assert property (O_HALTED && I_CORE_WAKE
		|=> !O_HALTED) else $error("halt not left on wake");
	a_stop_entry: assert property (I_STOP_ENTER && !O_DEVICE_RESET
		&& !O_HALTED |=> O_STOPPED) else $error("stop not entered");
endmodule : srwd_ctrl_monitor

bind srwd_ctrl srwd_ctrl_monitor u_mon (
	.I_MCLK(I_MCLK), .I_RST(I_RST), .I_AVS_READ(I_AVS_READ),
	.I_AVS_WRITE(I_AVS_WRITE), .O_AVS_READDATA(O_AVS_READDATA),
	.O_AVS_WAITREQUEST(O_AVS_WAITREQUEST), .I_WDT_INSTR(I_WDT_INSTR),
	.I_HALT_ENTER(I_HALT_ENTER), .I_STOP_ENTER(I_STOP_ENTER),
	.I_CORE_WAKE(I_CORE_WAKE), .O_FLAGS_ZSV(O_FLAGS_ZSV),
	.O_FLAGS_WE(O_FLAGS_WE), .I_SUPPLY_LOW(I_SUPPLY_LOW),
	.O_DEVICE_RESET(O_DEVICE_RESET), .O_STOPPED(O_STOPPED),
	.O_HALTED(O_HALTED));

// ==== testbench/srwd_core_model.sv ====
// srwd_core_model: processor core issuing watchdog and sleep strobes
// assumes bench commands are one-cycle levels on the same clock
`timescale 1ns/1ps
module srwd_core_model (
	// commands
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic        i_en,
	input  wire logic [15:0] i_gap,
	input  wire logic        i_asleep,
	input  wire logic        i_halt_req,
	input  wire logic        i_stop_req,
	input  wire logic        i_wake_req,
	// core strobes
	output logic             o_wdt_instr,
	output logic             o_halt_enter,
	output logic             o_stop_enter,
	output logic             o_core_wake
);
	logic [15:0] cnt_q;

	// a sleeping core executes nothing, so it cannot refresh
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			cnt_q       <= 16'h0;
			o_wdt_instr <= 1'b0;
		end else begin
			o_wdt_instr <= i_en && !i_asleep && cnt_q == i_gap;
			cnt_q       <= (!i_en || cnt_q == i_gap) ? 16'h0 : cnt_q + 16'h1;
		end
	end
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_halt_enter <= 1'b0;
			o_stop_enter <= 1'b0;
			o_core_wake  <= 1'b0;
		end else begin
			o_halt_enter <= i_halt_req;
			o_stop_enter <= i_stop_req;
			o_core_wake  <= i_wake_req;
		end
	end
endmodule : srwd_core_model

// ==== testbench/tb_top.sv ====
// tb_top: register, stop-wake and watchdog scenarios for srwd_ctrl
// assumes block reset skips the slow one-shot; run is about 39k clocks
`timescale 1ns/1ps
module tb_top;
	import srwd_pkg::*;
	localparam int WDT_CLK = 256 * SRWD_XTAL_DIV;
	localparam int LIMIT   = 60000;
	logic        mclk, rst, rd, wr, sup_low, clr_n, en, hreq, sreq, wreq;
	logic [7:0]  addr, p2;
	logic [2:0]  p3, zsv;
	logic [31:0] wdata, rdata, got;
	logic [15:0] gap;
	logic        wait_req, flags_we, dev_rst, stopped, halted;
	logic        wdt_i, halt_i, stop_i, wake_i;
	int          n_errors = 0;
	int          n_checks = 0;
	int          cyc = 0;
	int          t0;

	srwd_ctrl DUT (.I_MCLK(mclk), .I_RST(rst), .I_AVS_ADDRESS(addr),
		.I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata),
		.O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(wait_req),
		.I_WDT_INSTR(wdt_i), .I_HALT_ENTER(halt_i), .I_STOP_ENTER(stop_i),
		.I_CORE_WAKE(wake_i), .O_FLAGS_ZSV(zsv), .O_FLAGS_WE(flags_we),
		.I_PORT2_IN(p2), .I_PORT3_IN(p3), .I_SUPPLY_LOW(sup_low),
		.I_RESET_CLEAR_FIRST_N(clr_n), .I_RESET_CLEAR_SECOND_N(clr_n),
		.O_DEVICE_RESET(dev_rst), .O_STOPPED(stopped), .O_HALTED(halted));
	srwd_core_model u_core (.i_clk(mclk), .i_rst(rst), .i_en(en),
		.i_gap(gap), .i_asleep(stopped | halted), .i_halt_req(hreq),
		.i_stop_req(sreq), .i_wake_req(wreq), .o_wdt_instr(wdt_i),
		.o_halt_enter(halt_i), .o_stop_enter(stop_i), .o_core_wake(wake_i));

	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected at %0t: got %h exp %h", $time, g, e);
		end
	endtask : chk
	// one transfer; holds until waitrequest is seen low at an edge
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [7:0] d);
		@(posedge mclk);
		addr  <= a;
		wdata <= {24'h0, d};
		wr    <= w;
		rd    <= ~w;
		@(posedge mclk);
		while (wait_req !== 1'b0) @(posedge mclk);
		got = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask : bus
	task automatic core_cmd(input logic [2:0] c);
		@(posedge mclk);
		{hreq, sreq, wreq} <= c;
		@(posedge mclk);
		{hreq, sreq, wreq} <= 3'h0;
	endtask : core_cmd
	task automatic complete_run;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : complete_run

	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			n_errors++;
			complete_run();
		end
	end

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	initial begin
		{rst, rd, wr, sup_low, clr_n, en, hreq, sreq, wreq} = 9'h110;
		addr  = 8'h00;
		wdata = 32'h0;
		p2    = 8'h00;
		p3    = 3'h0;
		gap   = 16'h0;
		repeat (6) @(posedge mclk);
		rst   <= 1'b0;
		while (dev_rst !== 1'b0) @(posedge mclk);
		// crystal source, tap 00, halt off, reserved bits set
		bus(1'b1, SRWD_OFF_WDM, 8'hf0);
		bus(1'b0, SRWD_OFF_WDM, 8'h00);
		chk(got, 32'h0);
		bus(1'b0, SRWD_OFF_SRC, 8'h00);
		chk(got, 32'h0);
		// high-level wake on the first port 3 pin, no delay
		bus(1'b1, SRWD_OFF_SRC, 8'h48);
		core_cmd(3'b010);
		repeat (50) @(posedge mclk);
		chk({31'h0, stopped}, 32'h1);
		bus(1'b0, SRWD_OFF_SRC, 8'h00);
		chk(got, 32'h80);
		p3 <= 3'h1;
		for (int i = 0; i < 2000 && stopped !== 1'b0; i++) @(posedge mclk);
		chk({31'h0, stopped}, 32'h0);
		while (dev_rst !== 1'b0) @(posedge mclk);
		p3 <= 3'h0;
		bus(1'b1, SRWD_OFF_SRC, 8'h08);
		bus(1'b0, SRWD_OFF_SRC, 8'h00);
		chk(got, 32'h80);
		// slow but timely refreshes never let it expire
		gap <= 16'd3000;
		en  <= 1'b1;
		repeat (16000) @(posedge mclk);
		chk({31'h0, dev_rst}, 32'h0);
		bus(1'b1, SRWD_OFF_WDM, 8'h03);
		do @(posedge mclk); while (wdt_i !== 1'b1);
		en <= 1'b0;
		core_cmd(3'b100);
		repeat (2 * WDT_CLK) @(posedge mclk);
		chk({30'h0, halted, dev_rst}, 32'h2);
		core_cmd(3'b001);
		gap <= 16'd10;
		en  <= 1'b1;
		do @(posedge mclk); while (wdt_i !== 1'b1);
		en <= 1'b0;
		t0 = cyc;
		while (dev_rst !== 1'b1) @(posedge mclk);
		chk({31'h0, (cyc - t0 >= WDT_CLK - SRWD_XTAL_DIV) &&
			(cyc - t0 <= WDT_CLK + SRWD_XTAL_DIV + 8)}, 32'h1);
		bus(1'b0, SRWD_OFF_SRC, 8'h00);
		chk(got, 32'h0);
		// past the 18-clock timer, so only the one-shot can hold it
		repeat (1000) @(posedge mclk);
		chk({31'h0, dev_rst}, 32'h1);
		sup_low <= 1'b1;
		repeat (5) @(posedge mclk);
		chk({31'h0, dev_rst}, 32'h1);
		complete_run();
	end
endmodule : tb_top
